// *** hw/dmic_pkg.sv ***
package dmic_pkg;

   // Register byte addresses
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] DIV_OFFSET    = 4'h4;
   localparam logic [3:0] STATUS_OFFSET = 4'h8;
   localparam logic [3:0] DATA_OFFSET   = 4'hc;

   // Control field positions
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_LEFT_BIT   = 1;
   localparam int CTRL_RIGHT_BIT  = 2;
   localparam int CTRL_RATIO_LSB  = 3;

   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
   localparam logic [7:0]  DIV_RESET  = 8'h04;

   // Oversampling ratio codes
   typedef enum logic [1:0] {
      RATIO_128,
      RATIO_64,
      RATIO_32,
      RATIO_RSVD
   } ratio_t;

   localparam logic [7:0] RATIO_128_PERIODS = 8'h80;
   localparam logic [7:0] RATIO_64_PERIODS  = 8'h40;
   localparam logic [7:0] RATIO_32_PERIODS  = 8'h20;

   // Gain shifts so every ratio spans the same output range
   localparam logic [3:0] SHIFT_128 = 4'h7;
   localparam logic [3:0] SHIFT_64  = 4'h8;
   localparam logic [3:0] SHIFT_32  = 4'h9;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Periods per output sample for a ratio code
   function automatic logic [7:0] ratio_periods(input logic [1:0] code);
      case (code)
         2'b01:   ratio_periods = RATIO_64_PERIODS;
         2'b10:   ratio_periods = RATIO_32_PERIODS;
         default: ratio_periods = RATIO_128_PERIODS;
      endcase
   endfunction : ratio_periods

   // Scaling shift for a ratio code
   function automatic logic [3:0] ratio_shift(input logic [1:0] code);
      case (code)
         2'b01:   ratio_shift = SHIFT_64;
         2'b10:   ratio_shift = SHIFT_32;
         default: ratio_shift = SHIFT_128;
      endcase
   endfunction : ratio_shift

endpackage : dmic_pkg

// *** hw/dmic_bits_if.sv ***
`timescale 1ns/10ps
// Captured bits from the pin logic to the decimator, all in link domain
interface dmic_bits_if;
   logic        run;
   logic [1:0]  ratio;
   logic        left_stb;
   logic        right_stb;
   logic        left_bit;
   logic        right_bit;
   logic        period_stb;
   logic [15:0] left_word;
   logic [15:0] right_word;
   logic        word_tgl;

   modport capture (
      output run,
      output ratio,
      output left_stb,
      output right_stb,
      output left_bit,
      output right_bit,
      output period_stb,
      input  left_word,
      input  right_word,
      input  word_tgl
   );

   modport decim (
      input  run,
      input  ratio,
      input  left_stb,
      input  right_stb,
      input  left_bit,
      input  right_bit,
      input  period_stb,
      output left_word,
      output right_word,
      output word_tgl
   );
endinterface : dmic_bits_if

// *** hw/dmic_decimator.sv ***
`timescale 1ns/10ps
// Boxcar decimator on the one-bit streams, link clock domain
module dmic_decimator
   import dmic_pkg::*;
(
   input wire logic   link_clk,
   input wire logic   link_rst_n,
   dmic_bits_if.decim bits
);

   logic [7:0]  period_cnt_q;
   logic [7:0]  left_ones_q;
   logic [7:0]  right_ones_q;
   logic [15:0] left_word_q;
   logic [15:0] right_word_q;
   logic        word_tgl_q;
   logic        last_period;
   logic [7:0]  left_total;
   logic [7:0]  right_total;

   // Signed pcm from a ones count
   function automatic logic [15:0] to_pcm(input logic [7:0] ones,
                                          input logic [1:0] code);
      logic signed [16:0] diff;
      diff   = 17'($signed({1'b0, ones, 1'b0})) -
               17'($signed({1'b0, ratio_periods(code)}));
      to_pcm = 16'(diff <<< ratio_shift(code));
   endfunction : to_pcm

   // Ones including a bit that lands on the sample boundary
   assign left_total  = left_ones_q +
                        {7'h00, bits.left_stb && bits.left_bit};
   assign right_total = right_ones_q +
                        {7'h00, bits.right_stb && bits.right_bit};

   assign last_period = bits.period_stb &&
                        (period_cnt_q == ratio_periods(bits.ratio) - 8'h01);

   // Mic clock periods per output sample
   always_ff @(posedge link_clk) begin
      if (!link_rst_n || !bits.run) begin
         period_cnt_q <= 8'h00;
      end else if (last_period) begin
         period_cnt_q <= 8'h00;
      end else if (bits.period_stb) begin
         period_cnt_q <= period_cnt_q + 8'h01;
      end
   end

   // Ones counters, restart each sample
   always_ff @(posedge link_clk) begin
      if (!link_rst_n || !bits.run || last_period) begin
         left_ones_q  <= 8'h00;
         right_ones_q <= 8'h00;
      end else begin
         if (bits.left_stb && bits.left_bit) begin
            left_ones_q <= left_ones_q + 8'h01; // R7
         end
         if (bits.right_stb && bits.right_bit) begin
            right_ones_q <= right_ones_q + 8'h01; // R7
         end
      end
   end

   // Output words held for a whole sample, toggle marks new pair
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         left_word_q  <= 16'h0000;
         right_word_q <= 16'h0000;
         word_tgl_q   <= 1'b0;
      end else if (last_period) begin
         left_word_q  <= to_pcm(left_total, bits.ratio);  // R7
         right_word_q <= to_pcm(right_total, bits.ratio); // R7
         word_tgl_q   <= ~word_tgl_q;
      end
   end

   assign bits.left_word  = left_word_q;
   assign bits.right_word = right_word_q;
   assign bits.word_tgl   = word_tgl_q;

endmodule : dmic_decimator

// *** hw/dmic_input.sv ***
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
// Rules for this block, the host and the mic
// R1 - While mic mode is on, generate and drive the oversampling clock.
// R2 - Capture on rising, falling or both edges, by configuration.
// R3 - Mic clock is 128, 64 or 32 times the sample rate.
// R4 - Drive the clock at the programmed ratio onto the mic clock pin.
// R5 - Bit sampled at each rising clock edge is left channel.
// R6 - Bit sampled at each falling clock edge is right channel.
// R7 - Captured bitstream feeds the decimation filter, result goes to host.
// R8 - While mic mode is on, neither ADC digitizes analog inputs.
// R9 - Host powers up only the ADC channel matching a single mic.
// R10 - Mic holds left data at rising, right data at falling edges.
// R11 - Mic clock has roughly equal high and low phases.
module dmic_input
   import dmic_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        link_clk,
   // AXI4-Lite slave
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output wire logic        s_axi_wready,
   output wire logic [1:0]  s_axi_bresp,
   output wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output wire logic        s_axi_arready,
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0]  s_axi_rresp,
   output wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Microphone pins
   output wire logic        mic_clock_pin,
   input  wire logic        mic_data_pin,
   // Decimated samples toward the audio serial bus
   output wire logic [15:0] pcm_left,
   output wire logic [15:0] pcm_right,
   output wire logic        pcm_valid,
   // Analog front end permitted to feed the ADCs
   output wire logic        adc_analog_enable
);

   // ---------------- Register bus, aclk domain ----------------
   logic [31:0] ctrl_q;
   logic [7:0]  div_q;
   logic [3:0]  awaddr_q;
   logic        aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        w_held_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;
   logic        do_write;
   logic [15:0] sample_cnt_q;

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      merge = res;
   endfunction : merge

   // Which register a write address selects, zero for none
   function automatic logic [1:0] wr_sel(input logic [3:0] addr);
      case (addr)
         CTRL_OFFSET: wr_sel = 2'b01;
         DIV_OFFSET:  wr_sel = 2'b10;
         default:     wr_sel = 2'b00;
      endcase
   endfunction : wr_sel

   // Each half taken whenever nothing of it is held
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready  = !w_held_q;
   assign do_write      = aw_held_q && w_held_q && !bvalid_q;

   // Write address holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 4'h0;
      end else if (s_axi_awvalid && !aw_held_q) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   // Write data holding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && !w_held_q) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   // Register writes; reserved control bits stay zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
         div_q  <= DIV_RESET;
      end else if (do_write) begin
         if (wr_sel(awaddr_q) == 2'b01) begin
            ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_001f;
         end else if (wr_sel(awaddr_q) == 2'b10 && wstrb_q[0]) begin
            // Half period of zero would wrap to a 256-cycle half period in the divider
            div_q <= (wdata_q[7:0] == 8'h00) ? 8'h01 : wdata_q[7:0];
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (wr_sel(awaddr_q) != 2'b00) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Response out, read address refused while data waits
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;

   // ---------------- Link domain ----------------
   logic [2:0]  rst_sync_q;
   logic        link_rst_n;
   logic        run_s1_q;
   logic        run_s2_q;
   logic [4:0]  cfg_s1_q;
   logic [4:0]  cfg_s2_q;
   logic [7:0]  half_s1_q;
   logic [7:0]  half_s2_q;
   logic        data_s1_q;
   logic        data_s2_q;
   logic        mic_clk_q;
   logic [7:0]  half_cnt_q;
   logic        flip;
   logic        rise_ev;
   logic        fall_ev;
   logic        run_q;
   logic [4:0]  cfg_run_q;
   logic [7:0]  half_run_q;

   // Carrier from pin logic to decimator
   dmic_bits_if bits ();

   // Reset into link domain
   always_ff @(posedge link_clk) begin
      rst_sync_q <= {rst_sync_q[1:0], aresetn};
   end
   // Only the third flop leaves the synchroniser
   assign link_rst_n = rst_sync_q[2];

   // Quasi-static configuration crossed by two flops
   always_ff @(posedge link_clk) begin
      run_s1_q  <= ctrl_q[CTRL_ENABLE_BIT];
      run_s2_q  <= run_s1_q;
      cfg_s1_q  <= ctrl_q[4:0];
      cfg_s2_q  <= cfg_s1_q;
      half_s1_q <= div_q;
      half_s2_q <= half_s1_q;
   end

   // Data pin synchroniser
   always_ff @(posedge link_clk) begin
      data_s1_q <= mic_data_pin;
      data_s2_q <= data_s1_q;
   end

   // Registered run flag, crosses back to aclk without glitches
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         run_q <= 1'b0;
      end else begin
         run_q <= run_s2_q;
      end
   end

   // Settings frozen while running so no sample mixes two ratios
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         cfg_run_q  <= CTRL_RESET[4:0];
         half_run_q <= DIV_RESET;
      end else if (!run_q) begin
         cfg_run_q  <= cfg_s2_q;
         half_run_q <= half_s2_q;
      end
   end

   // Divider flip point and the clock edges it makes
   assign bits.run   = run_q;
   assign bits.ratio = cfg_run_q[CTRL_RATIO_LSB +: 2];
   assign flip       = bits.run && (half_cnt_q >= half_run_q - 8'h01);
   assign rise_ev    = flip && !mic_clk_q;
   assign fall_ev    = flip && mic_clk_q;

   // Mic clock divider, equal halves, low while idle
   always_ff @(posedge link_clk) begin
      if (!bits.run) begin
         half_cnt_q <= 8'h00;
         mic_clk_q  <= 1'b0;
      end else if (flip) begin
         half_cnt_q <= 8'h00;         // R11
         mic_clk_q  <= ~mic_clk_q;    // R1
      end else begin
         half_cnt_q <= half_cnt_q + 8'h01;
      end
   end

   // Pin driven straight from the divider flop
   assign mic_clock_pin = mic_clk_q; // R4

   // Edge-selected capture of the shared data line
   assign bits.left_stb   = rise_ev && cfg_run_q[CTRL_LEFT_BIT];  // R2 R5
   assign bits.right_stb  = fall_ev && cfg_run_q[CTRL_RIGHT_BIT]; // R2 R6
   assign bits.left_bit   = data_s2_q;  // R5 R10
   assign bits.right_bit  = data_s2_q;  // R6 R10
   assign bits.period_stb = rise_ev;    // R3

   // Boxcar filter on the captured streams
   dmic_decimator u_decim (
      .link_clk   (link_clk),
      .link_rst_n (link_rst_n),
      .bits       (bits.decim)
   );

   // ---------------- Samples back to aclk ----------------
   logic [2:0]  tgl_sync_q;
   logic [1:0]  run_back_q;
   logic [15:0] pcm_left_q;
   logic [15:0] pcm_right_q;
   logic        pcm_valid_q;
   logic        new_word;

   // Toggle synchroniser; edge taken from second and third flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tgl_sync_q <= 3'b000;
         run_back_q <= 2'b00;
      end else begin
         tgl_sync_q <= {tgl_sync_q[1:0], bits.word_tgl};
         run_back_q <= {run_back_q[0], bits.run};
      end
   end
   // One aclk pulse per crossed toggle
   assign new_word = tgl_sync_q[2] ^ tgl_sync_q[1];

   // Words are stable a whole sample, safe to take here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pcm_left_q  <= 16'h0000;
         pcm_right_q <= 16'h0000;
         pcm_valid_q <= 1'b0;
      end else begin
         pcm_valid_q <= new_word; // R7
         if (new_word) begin
            pcm_left_q  <= bits.left_word;
            pcm_right_q <= bits.right_word;
         end
      end
   end

   // Samples delivered since enable
   // Held at all ones rather than wrapping
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_q[CTRL_ENABLE_BIT]) begin
         sample_cnt_q <= 16'h0000;
      end else if (new_word && sample_cnt_q != 16'hffff) begin
         sample_cnt_q <= sample_cnt_q + 16'h0001;
      end
   end

   // Samples straight from their flops
   assign pcm_left  = pcm_left_q;
   assign pcm_right = pcm_right_q;
   assign pcm_valid = pcm_valid_q;

   // Analog inputs locked out of the ADCs in mic mode
   assign adc_analog_enable = !ctrl_q[CTRL_ENABLE_BIT]; // R8

   // Read channel, answer one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (s_axi_arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         case (s_axi_araddr)
            CTRL_OFFSET:   rdata_q <= ctrl_q;
            DIV_OFFSET:    rdata_q <= {24'h000000, div_q};
            STATUS_OFFSET: rdata_q <= {sample_cnt_q, 15'h0000,
                                       run_back_q[1]};
            DATA_OFFSET:   rdata_q <= {pcm_right_q, pcm_left_q};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Read channel outputs
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

endmodule : dmic_input

// *** verif/dmic_input_props.sv ***
`timescale 1ns/10ps
// Port checks on the mic input block
module dmic_input_props (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        link_clk,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        mic_clock_pin,
   input wire logic [15:0] pcm_left,
   input wire logic        pcm_valid,
   input wire logic        adc_analog_enable
);
   logic [8:0] run_q;
   logic [8:0] half_q;
   logic [1:0] ntog_q;
   logic       pin_q;
   logic       edge_d;

   assign edge_d = pin_q != mic_clock_pin;

   // Half period lengths of the mic clock
   always_ff @(posedge link_clk) begin
      pin_q  <= mic_clock_pin;
      run_q  <= edge_d ? 9'h1 : run_q + 9'h1;
      half_q <= edge_d ? run_q : half_q;
      if (!aresetn || adc_analog_enable) begin
         ntog_q <= 2'h0;
      end else if (edge_d && ntog_q != 2'h3) begin
         ntog_q <= ntog_q + 2'h1;
      end
   end

   property p_equal_halves;
      @(posedge link_clk) disable iff (!aresetn)
      edge_d && ntog_q[1] |-> run_q == half_q;
   endproperty
   a_equal_halves: assert property (p_equal_halves)
      else $error("mic clock halves differ");
   property p_pin_idle;
      @(posedge link_clk) disable iff (!aresetn)
      adc_analog_enable [*8] |-> !mic_clock_pin;
   endproperty
   a_pin_idle: assert property (p_pin_idle)
      else $error("mic clock runs while mic mode off");
   property p_aw_hold;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
   endproperty
   a_aw_hold: assert property (p_aw_hold)
      else $error("address ready while address held");
   property p_b_lat;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_b_lat: assert property (p_b_lat)
      else $error("write response latency wrong");
   property p_r_lat;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat)
      else $error("read data late");
   property p_pcm_pulse;
      @(posedge aclk) disable iff (!aresetn)
      pcm_valid |=> !pcm_valid;
   endproperty
   a_pcm_pulse: assert property (p_pcm_pulse)
      else $error("sample strobe longer than one cycle");
   property p_pcm_hold;
      @(posedge aclk) disable iff (!aresetn)
      !pcm_valid |-> $stable(pcm_left);
   endproperty
   a_pcm_hold: assert property (p_pcm_hold)
      else $error("sample changed without strobe");
   property p_pcm_range;
      @(posedge aclk) disable iff (!aresetn)
      pcm_valid |-> $signed(pcm_left) >= -16384 && $signed(pcm_left) <= 16384;
   endproperty
   a_pcm_range: assert property (p_pcm_range)
      else $error("sample out of range");
endmodule : dmic_input_props

bind dmic_input dmic_input_props dmic_input_props_i (
   .aclk              (aclk),
   .aresetn           (aresetn),
   .link_clk          (link_clk),
   .s_axi_awvalid     (s_axi_awvalid),
   .s_axi_awready     (s_axi_awready),
   .s_axi_wvalid      (s_axi_wvalid),
   .s_axi_wready      (s_axi_wready),
   .s_axi_bvalid      (s_axi_bvalid),
   .s_axi_arvalid     (s_axi_arvalid),
   .s_axi_arready     (s_axi_arready),
   .s_axi_rvalid      (s_axi_rvalid),
   .mic_clock_pin     (mic_clock_pin),
   .pcm_left          (pcm_left),
   .pcm_valid         (pcm_valid),
   .adc_analog_enable (adc_analog_enable)
);

// *** verif/mic_model.sv ***
`timescale 1ns/10ps
// Stereo mic pair sharing one data line
module mic_model (
   input  wire logic       mic_clock_pin,
   input  wire logic [1:0] left_mode,
   input  wire logic [1:0] right_mode,
   input  wire logic       slow,
   output logic            mic_data_pin
);
   int unsigned lcnt = 0;
   int unsigned rcnt = 0;

   // Pattern bit: zeros, ones, alternate, one in four
   function automatic logic pat(input logic [1:0] m, input int unsigned c);
      case (m)
         2'h0:    pat = 1'h0;
         2'h1:    pat = 1'h1;
         2'h2:    pat = c[0];
         default: pat = c[1:0] == 2'h0;
      endcase
   endfunction : pat

   initial mic_data_pin = 1'h0;
   // Left bit set up after fall, stable over the rise
   always @(negedge mic_clock_pin) begin
      #(slow ? 8 : 1);
      mic_data_pin = pat(left_mode, lcnt);
      lcnt++;
   end
   // Right bit set up after rise, stable over the fall
   always @(posedge mic_clock_pin) begin
      #(slow ? 8 : 1);
      mic_data_pin = pat(right_mode, rcnt);
      rcnt++;
   end
endmodule : mic_model

// *** verif/digital_mic_input_interface_bench.sv ***
`timescale 1ns/10ps
// Register access, mic traffic and sample checks
module digital_mic_input_interface_bench import dmic_pkg::*;;
   logic        aclk = 1'h0, link_clk = 1'h0, aresetn = 1'h0;
   logic [3:0]  awaddr = '0, araddr = '0, wstrb = '0;
   logic        awvalid = '0, wvalid = '0, bready = '0;
   logic        arvalid = '0, rready = '0, slow = '0;
   logic [31:0] wdata = '0, rdata;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        mic_clk, mic_dat, pcm_valid, analog_en;
   logic [1:0]  bresp, rresp, lmode = '0, rmode = '0;
   logic [15:0] pcm_l, pcm_r;
   logic [7:0]  seed = 8'h33;
   int          n_errors = 0, n_compared = 0;

   initial forever #4 aclk = ~aclk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   dmic_input dmic_input_i (
      .aclk(aclk), .aresetn(aresetn), .link_clk(link_clk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .mic_clock_pin(mic_clk),
      .mic_data_pin(mic_dat), .pcm_left(pcm_l), .pcm_right(pcm_r),
      .pcm_valid(pcm_valid), .adc_analog_enable(analog_en));

   mic_model mic_model_i (.mic_clock_pin(mic_clk), .left_mode(lmode),
      .right_mode(rmode), .slow(slow), .mic_data_pin(mic_dat));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic int periods(input logic [1:0] r);
      periods = (r == 2'h1) ? 64 : (r == 2'h2) ? 32 : 128;
   endfunction : periods

   // Expected sample for pattern, ratio and capture bit
   function automatic logic [15:0] exp_pcm(input logic [1:0] m,
                                           input logic [1:0] r,
                                           input logic       cap);
      int n, sh, ones;
      n = periods(r);
      sh = (r == 2'h1) ? 8 : (r == 2'h2) ? 9 : 7;
      ones = (m == 2'h0) ? 0 : (m == 2'h1) ? n : (m == 2'h2) ? n / 2 : n / 4;
      if (!cap) ones = 0;
      exp_pcm = 16'((2 * ones - n) << sh);
   endfunction : exp_pcm

   task automatic wrap_up;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic cmp_val(input string what, input logic [31:0] e,
                          input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : cmp_val

   task automatic hang;
      n_errors++;
      wrap_up();
   endtask : hang

   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      r = bresp;
      bready <= 1'h0;
      if (i == 100) hang();
   endtask : axi_wr

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 100; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      if (i == 100) hang();
   endtask : axi_rd

   task automatic wait_pcm(output int cyc);
      cyc = 0;
      do begin
         @(negedge aclk);
         cyc++;
      end while (pcm_valid !== 1'h1 && cyc < 4000);
      if (cyc == 4000) hang();
   endtask : wait_pcm

   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0]  r, ratio;
      logic [7:0]  div;
      logic        capl, capr;
      int          gap, t, e;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(CTRL_OFFSET, d, r);
      cmp_val("ctrl reset", CTRL_RESET, d);
      axi_rd(DIV_OFFSET, d, r);
      cmp_val("div reset", {24'h0, DIV_RESET}, d);
      cmp_val("analog at reset", 32'h1, {31'h0, analog_en});
      axi_wr(STATUS_OFFSET, 32'hffff_ffff, r);
      cmp_val("status write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_rd(4'h2, d, r);
      cmp_val("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      for (t = 0; t < 6; t++) begin
         seed = lfsr(seed);
         ratio = (t < 3) ? 2'(t) : seed[1:0];
         lmode = seed[3:2];
         rmode = seed[5:4];
         slow = seed[6];
         seed = lfsr(seed);
         capl = t == 0 || seed[0];
         capr = t == 0 || seed[1];
         div = 8'h5 + {6'h0, seed[3:2]};
         axi_wr(DIV_OFFSET, {24'h0, div}, r);
         axi_wr(CTRL_OFFSET, {27'h0, ratio, capr, capl, 1'h0}, r);
         axi_wr(CTRL_OFFSET, {27'h0, ratio, capr, capl, 1'h1}, r);
         cmp_val("ctrl write resp", {30'h0, RESP_OKAY}, {30'h0, r});
         @(negedge aclk);
         cmp_val("analog in mic mode", 32'h0, {31'h0, analog_en});
         wait_pcm(gap);
         wait_pcm(gap);
         cmp_val("left sample", {16'h0, exp_pcm(lmode, ratio, capl)},
                 {16'h0, pcm_l});
         cmp_val("right sample", {16'h0, exp_pcm(rmode, ratio, capr)},
                 {16'h0, pcm_r});
         e = periods(ratio) * int'(div) * 3 / 2;
         cmp_val("sample spacing", 32'h1,
                 {31'h0, gap >= e - 2 && gap <= e + 2});
         axi_rd(DATA_OFFSET, d, r);
         cmp_val("data reg", {exp_pcm(rmode, ratio, capr),
                 exp_pcm(lmode, ratio, capl)}, d);
         axi_rd(STATUS_OFFSET, d, r);
         cmp_val("status", 32'h0002_0001, d);
         axi_wr(CTRL_OFFSET, 32'h6, r);
         @(negedge aclk);
         cmp_val("analog after mic mode", 32'h1, {31'h0, analog_en});
         repeat (20) @(posedge aclk);
         cmp_val("mic clock idle", 32'h0, {31'h0, mic_clk});
      end
      wrap_up();
   end
endmodule : digital_mic_input_interface_bench
